/* File: tone_digit_pkg.sv */
// constants for the tone/dial digit recoder
// assumes a 25 MHz system clock
`default_nettype none
package tone_digit_pkg;
	localparam int CLK_HZ = 25000000;
	// end-of-dial timeout, in milliseconds
	localparam int DIAL_TIMEOUT_MS = 200;
	localparam int DIAL_TIMEOUT_CYCLES = DIAL_TIMEOUT_MS * (CLK_HZ / 1000);
	// slowest dial gap, 8 pulses per second, in milliseconds
	localparam int SLOW_GAP_MS = 125;
	localparam int SLOW_GAP_CYCLES = SLOW_GAP_MS * (CLK_HZ / 1000);
	localparam int TIMER_W = 23;
	localparam int CODE_W = 4;
	localparam int LINES = 16;
	// reset values
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic [15:0] LINE_RESET = 16'h0001;
	// receiver codes of interest
	localparam logic [3:0] CODE_ZERO = 4'hA;
	localparam logic [3:0] CODE_STAR = 4'hB;
	localparam logic [3:0] CODE_B = 4'hE;
	localparam logic [3:0] CODE_C = 4'hF;
	localparam logic [3:0] CODE_D = 4'h0;
	// recoded values
	localparam logic [3:0] RECODE_ZERO = 4'h0;
	localparam logic [3:0] RECODE_STAR = 4'h1;
	localparam logic [3:0] RECODE_B = 4'h4;
	localparam logic [3:0] RECODE_C = 4'h5;
	localparam logic [3:0] RECODE_D = 4'h0;
	// 2-of-8 field positions in the binary code
	localparam int ROW_MSB = 3;
	localparam int ROW_LSB = 2;
	localparam int COL_MSB = 1;
	localparam int COL_LSB = 0;
	// column line of the 1633 Hz tone
	localparam int COL_HIGH_TONE = 3;
endpackage : tone_digit_pkg
`default_nettype wire

/* File: tone_digit_code_recoder.sv */
// tone digit recoder, line decoders and rotary dial pulse counter
// assumes asynchronous receiver and loop detector pins, one system clock
`default_nettype none
module tone_digit_code_recoder
	import tone_digit_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = DIAL_TIMEOUT_CYCLES,
	parameter int GAP_CYCLES = SLOW_GAP_CYCLES
)
(
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// receiver code pins
	input wire logic code_weight_eight,
	input wire logic code_weight_four,
	input wire logic code_weight_two,
	input wire logic code_weight_one,
	input wire logic tone_code_valid,
	// loop detector pin, high is break
	input wire logic loop_detect,
	// configuration levels
	input wire logic gate_with_valid,
	input wire logic inhibit_high_tone,
	// latched digit
	output logic [3:0] digit_output_latch,
	output logic digit_strobe,
	// decoded forms
	output logic [3:0] recoded_digit,
	output logic [15:0] line_select,
	output logic [3:0] row_lines,
	output logic [3:0] col_lines,
	// dial state
	output logic [3:0] dial_pulse_counter,
	output logic timer_active_low_out
);

	////////////////////////////////////////////////////////////////////////
	// synchronisers

	logic [3:0] code_meta, code_sync;
	logic valid_meta, valid_sync, valid_prev;
	logic loop_meta, loop_sync, loop_prev;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			code_meta <= CODE_RESET;
			code_sync <= CODE_RESET;
			valid_meta <= 1'b0;
			valid_sync <= 1'b0;
			valid_prev <= 1'b0;
			loop_meta <= 1'b0;
			loop_sync <= 1'b0;
			loop_prev <= 1'b0;
		end
		else
		begin
			code_meta <= {code_weight_eight, code_weight_four,
				code_weight_two, code_weight_one};
			code_sync <= code_meta;
			valid_meta <= tone_code_valid;
			valid_sync <= valid_meta;
			valid_prev <= valid_sync;
			loop_meta <= loop_detect;
			loop_sync <= loop_meta;
			loop_prev <= loop_sync;
		end
	end

	logic tone_load, pulse_edge;

	// code is stable while valid is high, so sample on its rise
	assign tone_load = valid_sync & ~valid_prev;
	// start of a break is one dial pulse
	assign pulse_edge = loop_sync & ~loop_prev;

	////////////////////////////////////////////////////////////////////////
	// end of dial timer

	logic [TIMER_W-1:0] end_of_dial_timer;
	logic expiry;
	logic dial_load;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			end_of_dial_timer <= '0;
			timer_active_low_out <= 1'b1;
		end
		else if (pulse_edge)
		begin
			end_of_dial_timer <= TIMER_W'(TIMEOUT_CYCLES - 1);
			timer_active_low_out <= 1'b0;
		end
		else if (!timer_active_low_out)
		begin
			if (end_of_dial_timer == '0)
				timer_active_low_out <= 1'b1;
			else
				end_of_dial_timer <= end_of_dial_timer - 1'b1;
		end
	end

	assign expiry = !timer_active_low_out && end_of_dial_timer == '0
		&& !pulse_edge;
	// a held break means on-hook, keep the latch clock off
	assign dial_load = expiry & ~loop_sync;

	////////////////////////////////////////////////////////////////////////
	// dial pulse counter

	logic count_pending;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			count_pending <= 1'b0;
		else
			count_pending <= pulse_edge;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			dial_pulse_counter <= CODE_RESET;
		else if (pulse_edge && timer_active_low_out)
			dial_pulse_counter <= CODE_RESET;
		else if (count_pending)
			dial_pulse_counter <= dial_pulse_counter + 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// shared output latch

	logic [3:0] latch_in;

	// ten pulses give 1010, the same code the receiver uses for zero
	assign latch_in = (tone_load ? code_sync : CODE_RESET)
		| (dial_load ? dial_pulse_counter : CODE_RESET);

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			digit_output_latch <= CODE_RESET;
			digit_strobe <= 1'b0;
		end
		else
		begin
			digit_strobe <= tone_load | dial_load;
			if (tone_load || dial_load)
				digit_output_latch <= latch_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// decoders from the latched code

	function automatic logic [3:0] recode(input logic [3:0] code);
		logic [3:0] r;
		r = code;
		case (code)
			CODE_ZERO: r = RECODE_ZERO;
			CODE_STAR: r = RECODE_STAR;
			CODE_B: r = RECODE_B;
			CODE_C: r = RECODE_C;
			CODE_D: r = RECODE_D;
			default: r = code;
		endcase
		return r;
	endfunction : recode

	logic [3:0] next_row, next_col;

	always_comb
	begin
		next_row = 4'h1 << digit_output_latch[ROW_MSB:ROW_LSB];
		next_col = 4'h1 << digit_output_latch[COL_MSB:COL_LSB];
		if (inhibit_high_tone)
			next_col[COL_HIGH_TONE] = 1'b0;
		if (gate_with_valid && (!valid_sync || tone_load))
		begin
			next_row = 4'h0;
			next_col = 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			recoded_digit <= CODE_RESET;
			line_select <= LINE_RESET;
			row_lines <= 4'h0;
			col_lines <= 4'h0;
		end
		else
		begin
			recoded_digit <= recode(digit_output_latch);
			line_select <= 16'h0001 << digit_output_latch;
			row_lines <= next_row;
			col_lines <= next_col;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_first_pulse;
		pulse_edge && timer_active_low_out;
	endsequence

	sequence s_clear_then_count;
		dial_pulse_counter == 4'h0 ##1 dial_pulse_counter == 4'h1;
	endsequence

	property p_zero_recode;
		@(posedge clk) disable iff (!rstn)
		digit_output_latch == 4'hA |=> recoded_digit == 4'h0;
	endproperty
	a_zero_recode: assert property (p_zero_recode)
		else $error("zero key not recoded to 0000");

	property p_recode_b;
		@(posedge clk) disable iff (!rstn)
		digit_output_latch == 4'hE |=> recoded_digit == 4'h4;
	endproperty
	a_recode_b: assert property (p_recode_b)
		else $error("key B not recoded to 0100");

	property p_line_tracks;
		@(posedge clk) disable iff (!rstn)
		##1 line_select == (16'h0001 << $past(digit_output_latch));
	endproperty
	a_line_tracks: assert property (p_line_tracks)
		else $error("sixteen-line output does not follow code");

	property p_inhibit;
		@(posedge clk) disable iff (!rstn)
		inhibit_high_tone |=> col_lines[3] == 1'b0;
	endproperty
	a_inhibit: assert property (p_inhibit)
		else $error("1633 Hz column active while inhibited");

	property p_gate;
		@(posedge clk) disable iff (!rstn)
		gate_with_valid && !valid_sync |=> row_lines == 4'h0
			&& col_lines == 4'h0;
	endproperty
	a_gate: assert property (p_gate)
		else $error("2-of-8 lines active without data-valid");

	property p_break_starts;
		@(posedge clk) disable iff (!rstn)
		pulse_edge |=> !timer_active_low_out;
	endproperty
	a_break_starts: assert property (p_break_starts)
		else $error("break did not start the timer");

	property p_first_clear;
		@(posedge clk) disable iff (!rstn)
		s_first_pulse |=> s_clear_then_count;
	endproperty
	a_first_clear: assert property (p_first_clear)
		else $error("first pulse not cleared then counted");

	property p_count_delayed;
		@(posedge clk) disable iff (!rstn)
		pulse_edge && !timer_active_low_out |=>
			$stable(dial_pulse_counter) ##1
			dial_pulse_counter == $past(dial_pulse_counter) + 4'h1;
	endproperty
	a_count_delayed: assert property (p_count_delayed)
		else $error("pulse count not one cycle after pulse");

	property p_load;
		@(posedge clk) disable iff (!rstn)
		dial_load && !tone_load |=> digit_strobe
			&& digit_output_latch == $past(dial_pulse_counter);
	endproperty
	a_load: assert property (p_load)
		else $error("timer expiry did not load count");

	property p_margin;
		@(posedge clk) disable iff (!rstn)
		TIMEOUT_CYCLES > GAP_CYCLES;
	endproperty
	a_margin: assert property (p_margin)
		else $error("timeout shorter than slow dial gap");

	property p_binary;
		@(posedge clk) disable iff (!rstn)
		count_pending && dial_pulse_counter == 4'h9 |=>
			dial_pulse_counter == 4'hA;
	endproperty
	a_binary: assert property (p_binary)
		else $error("counter not binary after nine");

	property p_tone_load;
		@(posedge clk) disable iff (!rstn)
		tone_load && !dial_load |=> digit_strobe
			&& digit_output_latch == $past(code_sync);
	endproperty
	a_tone_load: assert property (p_tone_load)
		else $error("tone code not latched");

	property p_onhook;
		@(posedge clk) disable iff (!rstn)
		expiry && loop_sync && !tone_load |=> !digit_strobe;
	endproperty
	a_onhook: assert property (p_onhook)
		else $error("latch loaded while loop held high");

endmodule : tone_digit_code_recoder
`default_nettype wire

/* File: line_side_model.sv */
// far side model: tone receiver outputs and telephone loop detector
// assumes the bench calls its tasks from one process at a time
`default_nettype none
module line_side_model
(
	// clock
	input wire logic clk,
	// receiver and loop pins
	output logic [3:0] code,
	output logic valid,
	output logic loop_level
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		code <= 4'h5;
		valid <= 1'b0;
		loop_level <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// code first, valid one cycle later
	task key(input logic [3:0] k);
		@(posedge clk) code <= k;
		@(posedge clk) valid <= 1'b1;
	endtask : key

	// valid drops, code lines no longer trustworthy
	task lift;
		@(posedge clk);
		valid <= 1'b0;
		code <= ~code;
	endtask : lift

	// break high, make low, short gaps
	task dial(input int n);
		repeat (n)
		begin
			@(posedge clk) loop_level <= 1'b1;
			repeat (4) @(posedge clk);
			loop_level <= 1'b0;
			repeat (5) @(posedge clk);
		end
	endtask : dial

	// on-hook: loop stays broken
	task hang_up;
		@(posedge clk) loop_level <= 1'b1;
	endtask : hang_up

	task pick_up;
		@(posedge clk) loop_level <= 1'b0;
	endtask : pick_up
endmodule : line_side_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the tone/dial digit recoder
// assumes a short end-of-dial timeout parameter for simulation
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TMO = 50;
	localparam int GAP = 20;
	logic clk, rstn, gate, inhibit, valid, loop_level, strobe, timer_n;
	logic [3:0] code, latch, recoded, row, col, count;
	logic [15:0] lines;
	int mismatches, num_checks;

	line_side_model u_far (.clk(clk), .code(code), .valid(valid),
		.loop_level(loop_level));
	tone_digit_code_recoder #(.TIMEOUT_CYCLES(TMO), .GAP_CYCLES(GAP))
		u_dut (.clk(clk),
		.rstn(rstn), .code_weight_eight(code[3]),
		.code_weight_four(code[2]), .code_weight_two(code[1]),
		.code_weight_one(code[0]), .tone_code_valid(valid),
		.loop_detect(loop_level), .gate_with_valid(gate),
		.inhibit_high_tone(inhibit), .digit_output_latch(latch),
		.digit_strobe(strobe), .recoded_digit(recoded),
		.line_select(lines), .row_lines(row), .col_lines(col),
		.dial_pulse_counter(count), .timer_active_low_out(timer_n));

	////////////////////////////////////////////////////////////////////////
	task check(input string what, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task wait_strobe(input int lim);
		int i;
		i = 0;
		while (strobe !== 1'b1 && i < lim)
		begin
			@(negedge clk);
			i++;
		end
		check("strobe", {15'h0, strobe}, 16'h0001);
	endtask : wait_strobe

	task conclude;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	task test_keys;
		logic [3:0] k, r;
		for (int i = 0; i < 16; i++)
		begin
			k = 4'(i);
			@(posedge clk) inhibit <= k[0];
			u_far.key(k);
			@(negedge clk);
			wait_strobe(8);
			check("latch", {12'h0, latch}, {12'h0, k});
			@(negedge clk);
			r = (k == 4'hA || k == 4'h0) ? 4'h0 : (k == 4'hB) ? 4'h1 :
				(k == 4'hE) ? 4'h4 : (k == 4'hF) ? 4'h5 : k;
			check("recode", {12'h0, recoded}, {12'h0, r});
			check("lines", lines, 16'h0001 << k);
			check("row", {12'h0, row}, {12'h0, 4'h1 << k[3:2]});
			check("col", {12'h0, col},
				{12'h0, (4'h1 << k[1:0]) & {~k[0], 3'h7}});
			u_far.lift();
			repeat (6) @(negedge clk);
			check("gated", {8'h0, row, col}, 16'h0000);
			check("held", lines, 16'h0001 << k);
		end
		$display("keys done");
	endtask : test_keys

	task test_dial(input int n);
		logic [3:0] e;
		e = 4'(n);
		u_far.dial(n);
		@(negedge clk);
		check("timer low", {15'h0, timer_n}, 16'h0000);
		wait_strobe(TMO + 10);
		check("count", {12'h0, count}, {12'h0, e});
		check("latch", {12'h0, latch}, {12'h0, e});
		@(negedge clk);
		check("timer high", {15'h0, timer_n}, 16'h0001);
		check("row", {12'h0, row}, {12'h0, 4'h1 << e[3:2]});
		$display("dial %0d done", n);
	endtask : test_dial

	task test_hook;
		int hits;
		hits = 0;
		u_far.hang_up();
		repeat (TMO + 20)
		begin
			@(negedge clk);
			hits += int'(strobe === 1'b1);
		end
		check("hook strobe", 16'(hits), 16'h0000);
		check("hook latch", {12'h0, latch}, 16'h000A);
		check("hook timer", {15'h0, timer_n}, 16'h0001);
		u_far.pick_up();
		$display("hook done");
	endtask : test_hook

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude;
	end

	initial
	begin
		rstn <= 1'b0;
		gate <= 1'b1;
		inhibit <= 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		check("reset latch", {12'h0, latch}, 16'h0000);
		check("reset lines", lines, 16'h0001);
		check("reset timer", {15'h0, timer_n}, 16'h0001);
		test_keys;
		@(posedge clk) gate <= 1'b0;
		test_dial(3);
		test_dial(10);
		test_hook;
		conclude;
	end
endmodule : tb_top
`default_nettype wire
